// ---- rtl/cmrs_map.svh ----
// Command codes, cache field selects and reset values of the rule store.
`ifndef CMRS_MAP_SVH
`define CMRS_MAP_SVH
`define CMRS_CMD_WRITE 3'h0
`define CMRS_CMD_READ 3'h1
`define CMRS_CMD_MOVE_DOWN 3'h2
`define CMRS_CMD_MOVE_UP 3'h3
`define CMRS_CMD_INIT 3'h4
`define CMRS_FLD_VALUE 3'h0
`define CMRS_FLD_MASK 3'h1
`define CMRS_FLD_ACTION 3'h2
`define CMRS_FLD_STICKY 3'h3
`define CMRS_FLD_WORDWIDE 3'h4
`define CMRS_WORD_W 32
`define CMRS_OWNER_FREE 3'h0
`define CMRS_SEL_W 4
`define CMRS_TYPE_W 4
`endif

// ---- rtl/cmrs_pkg.sv ----
// Types shared by the content-match rule store.
package cmrs_pkg;
  typedef enum logic [0:0] {OP_IDLE, OP_RUN} cmrs_state_type;
  typedef logic [2:0] cmrs_cmd_type;
  typedef logic [2:0] cmrs_field_type;
endpackage

// ---- rtl/content_match_rule_store.sv ----
// Ternary content-match rule store with cache-based software access and a lookup path.
// Behaviour
// - A rule is entry, action, counter; a hit returns the action, bumps the counter.
// - Exactly one rule answers; the highest matching address wins.
// - With no match, a software-programmed default rule answers.
// - The key generator picks the default rule together with the key.
// - Enabled lookups build a type/port key per frame, plus a type/class key on ports set in portSecondKey.
// - Software reaches rule memory only through a one-address cache.
// - Wide cache fields are split over 32-bit replicas, low bits in replica zero.
// - Every entry bit has a value bit and a mask bit.
// - The cache has one counter, accessed both as a word-wide value and as a sticky bit.
// - A control port starts read, write, move and init; a config gives ranges.
// - A block index and owner map allocate pool blocks to this lookup.
// - Value/mask 0/0 match 0, 0/1 any, 1/0 match 1, 1/1 disable entry.
// - Code, address and trigger come together; opBusy drops when done.
// - Counters saturate at their maximum instead of wrapping.
// - Cache clear disables the entry, zeros action and counter, before any write.
`timescale 1ns/1ps
`include "cmrs_map.svh"
module content_match_rule_store #(
  parameter int ENTRY_W = 52,
  parameter int ACTION_W = 110,
  parameter int CNT_W = 1,
  parameter int DEPTH = 32,
  parameter int BLOCK_SIZE = 8,
  parameter int NDEF = 2,
  parameter int PORT_W = 4,
  parameter logic [2:0] OWNER_ID = 3'h1
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Frame side from the pipeline.
  input wire logic lookupEnable,
  input wire logic frameValid,
  input wire logic [`CMRS_TYPE_W-1:0] frameType,
  input wire logic [PORT_W-1:0] framePort,
  input wire logic [`CMRS_SEL_W-1:0] classResult,
  input wire logic [ENTRY_W-`CMRS_TYPE_W-`CMRS_SEL_W-1:0] frameFields,
  input wire logic [$clog2(NDEF)-1:0] defaultSel,
  input wire logic [(1<<PORT_W)-1:0] portSecondKey,
  output logic frameReady,
  // Lookup result towards the action consumers.
  output logic resultValid,
  output logic resultHit,
  output logic resultKeyNum,
  output logic [$clog2(DEPTH+NDEF)-1:0] resultAddr,
  output logic [ACTION_W-1:0] resultAction,
  // Operation control and move range config.
  input wire logic operation_trigger,
  input wire logic [2:0] opCmd,
  input wire logic [$clog2(DEPTH+NDEF)-1:0] opAddr,
  input wire logic clearCache,
  input wire logic entryUpdateDis,
  input wire logic actionUpdateDis,
  input wire logic cntUpdateDis,
  input wire logic [$clog2(DEPTH+NDEF)-1:0] moveNumPos,
  input wire logic [$clog2(DEPTH+NDEF)-1:0] moveSize,
  output logic opBusy,
  // Cache register access.
  input wire logic cacheWrEn,
  input wire logic [2:0] cacheField,
  input wire logic [1:0] cacheReplica,
  input wire logic [`CMRS_WORD_W-1:0] cacheWrData,
  output logic [`CMRS_WORD_W-1:0] cacheRdData,
  // Pool block allocation.
  input wire logic poolIdxWrEn,
  input wire logic [$clog2(DEPTH/BLOCK_SIZE)-1:0] pool_block_index,
  input wire logic poolMapWrEn,
  input wire logic [2:0] pool_block_owner_map,
  output logic [2:0] poolOwnerRd
);
  localparam int AW = $clog2(DEPTH + NDEF);
  localparam int MEM = DEPTH + NDEF;
  localparam int NBLK = DEPTH / BLOCK_SIZE;
  localparam int BW = $clog2(NBLK);
  localparam int W = `CMRS_WORD_W;
  localparam int PADW = 4 * W;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic [ENTRY_W-1:0] memVal [MEM];
  logic [ENTRY_W-1:0] memMask [MEM];
  logic [ACTION_W-1:0] memAct [MEM];
  logic [CNT_W-1:0] memCnt [MEM];
  logic [2:0] owner_reg [NBLK];
  logic [BW-1:0] poolIdx_reg;
  logic [2:0] poolOwnerRd_reg, poolOwnerRd_next;

  logic [PADW-1:0] cacheVal, cacheMask, cacheAct;
  logic [CNT_W-1:0] cacheCnt;
  logic [W-1:0] cacheRdData_reg, cacheRdData_next;

  // Operation engine state.
  cmrs_pkg::cmrs_state_type state_reg, state_next;
  cmrs_pkg::cmrs_cmd_type cmd_reg, cmd_next;
  logic [AW-1:0] cur_reg, cur_next, remain_reg, remain_next, dist_reg, dist_next;
  logic [2:0] dis_reg, dis_next;
  logic opBusy_reg, opBusy_next;
  logic opStart;
  logic wrEn, clrSrcEn, loadEn;
  logic [AW-1:0] wrAddr, srcAddr;

  // Lookup state.
  logic keyPend_reg, keyPend_next;
  logic [ENTRY_W-1:0] key2_reg, key2_next, curKey, keyA;
  logic [$clog2(NDEF)-1:0] def2_reg, def2_next, curDef;
  logic lookupGo, anyHit;
  logic [DEPTH-1:0] hitVec;
  logic [AW-1:0] winIdx;
  logic resultValid_reg, resultValid_next, resultHit_reg, resultHit_next;
  logic resultKeyNum_reg, resultKeyNum_next, frameReady_reg, frameReady_next;
  logic [AW-1:0] resultAddr_reg, resultAddr_next;
  logic [ACTION_W-1:0] resultAction_reg, resultAction_next;

  // key build: first key carries the port, the optional second the class result.
  assign keyA = {frameType, `CMRS_SEL_W'(framePort), frameFields};
  assign lookupGo = keyPend_reg || (frameValid && frameReady_reg && lookupEnable);
  assign curKey = keyPend_reg ? key2_reg : keyA;
  assign curDef = keyPend_reg ? def2_reg : defaultSel;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gen_match
      // ternary match: any 1/1 pair disables, mask 1 ignores the key bit.
      assign hitVec[g] = (owner_reg[g / BLOCK_SIZE] == OWNER_ID) && !(|(memVal[g] & memMask[g])) &&
                         !(|(~memMask[g] & (memVal[g] ^ curKey)));
    end
  endgenerate

  always_comb begin
    anyHit = 1'b0;
    winIdx = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (hitVec[i]) begin
        anyHit = 1'b1;
        winIdx = AW'(i);
      end
    end
  end

  always_comb begin
    keyPend_next = keyPend_reg;
    key2_next = key2_reg;
    def2_next = def2_reg;
    resultValid_next = 1'b0;
    resultHit_next = resultHit_reg;
    resultKeyNum_next = resultKeyNum_reg;
    resultAddr_next = resultAddr_reg;
    resultAction_next = resultAction_reg;
    if (keyPend_reg) begin
      keyPend_next = 1'b0;
    end else if (frameValid && frameReady_reg && lookupEnable && portSecondKey[framePort]) begin
      keyPend_next = 1'b1;
      key2_next = {frameType, classResult, frameFields};
      def2_next = defaultSel;
    end
    if (lookupGo) begin
      resultValid_next = 1'b1;
      resultHit_next = anyHit;
      resultKeyNum_next = keyPend_reg;
      // matched rule or the chosen default answers.
      resultAddr_next = anyHit ? winIdx : AW'(DEPTH) + AW'(curDef);
      resultAction_next = memAct[resultAddr_next];
    end
    frameReady_next = !keyPend_next;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      keyPend_reg <= 1'b0;
      key2_reg <= '0;
      def2_reg <= '0;
      resultValid_reg <= 1'b0;
      resultHit_reg <= 1'b0;
      resultKeyNum_reg <= 1'b0;
      resultAddr_reg <= '0;
      resultAction_reg <= '0;
      frameReady_reg <= 1'b0;
    end else if (ce) begin
      keyPend_reg <= keyPend_next;
      key2_reg <= key2_next;
      def2_reg <= def2_next;
      resultValid_reg <= resultValid_next;
      resultHit_reg <= resultHit_next;
      resultKeyNum_reg <= resultKeyNum_next;
      resultAddr_reg <= resultAddr_next;
      resultAction_reg <= resultAction_next;
      frameReady_reg <= frameReady_next;
    end
  end

  // operation engine, one address per cycle.
  assign opStart = operation_trigger && !opBusy_reg;
  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    cur_next = cur_reg;
    remain_next = remain_reg;
    dist_next = dist_reg;
    dis_next = dis_reg;
    opBusy_next = opBusy_reg;
    wrEn = 1'b0;
    clrSrcEn = 1'b0;
    loadEn = 1'b0;
    wrAddr = cur_reg;
    srcAddr = cur_reg;
    case (state_reg)
      cmrs_pkg::OP_IDLE: begin
        if (opStart) begin
          state_next = cmrs_pkg::OP_RUN;
          opBusy_next = 1'b1;
          cmd_next = opCmd;
          dist_next = moveNumPos;
          dis_next = {cntUpdateDis, actionUpdateDis, entryUpdateDis};
          cur_next = (opCmd == `CMRS_CMD_MOVE_UP) ? opAddr + moveSize : opAddr;
          remain_next = (opCmd == `CMRS_CMD_INIT) ? moveNumPos :
                        (opCmd == `CMRS_CMD_MOVE_UP || opCmd == `CMRS_CMD_MOVE_DOWN) ? moveSize : '0;
        end
      end
      cmrs_pkg::OP_RUN: begin
        case (cmd_reg)
          `CMRS_CMD_READ: loadEn = 1'b1;
          `CMRS_CMD_MOVE_DOWN: begin
            wrAddr = cur_reg - dist_reg;
            clrSrcEn = 1'b1;
            loadEn = 1'b1;
          end
          `CMRS_CMD_MOVE_UP: begin
            wrAddr = cur_reg + dist_reg;
            clrSrcEn = 1'b1;
            loadEn = 1'b1;
          end
          default: wrEn = 1'b1;
        endcase
        // opBusy drops once the last address is done.
        if (remain_reg == '0) begin
          state_next = cmrs_pkg::OP_IDLE;
          opBusy_next = 1'b0;
        end else begin
          remain_next = remain_reg - AW'(1);
          cur_next = (cmd_reg == `CMRS_CMD_MOVE_UP) ? cur_reg - AW'(1) : cur_reg + AW'(1);
        end
      end
      default: state_next = cmrs_pkg::OP_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= cmrs_pkg::OP_IDLE;
      cmd_reg <= `CMRS_CMD_WRITE;
      cur_reg <= '0;
      remain_reg <= '0;
      dist_reg <= '0;
      dis_reg <= '0;
      opBusy_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      cur_reg <= cur_next;
      remain_reg <= remain_next;
      dist_reg <= dist_next;
      dis_reg <= dis_next;
      opBusy_reg <= opBusy_next;
    end
  end

  // rule memory, written only by the engine; lookups bump counters.
  always_ff @(posedge clk) begin
    if (ce) begin
      if (lookupGo && resultAddr_next < AW'(MEM) && memCnt[resultAddr_next] != {CNT_W{1'b1}}) begin
        memCnt[resultAddr_next] <= memCnt[resultAddr_next] + CNT_W'(1);
      end
      if (clrSrcEn) begin
        memVal[srcAddr] <= {ENTRY_W{1'b1}};
        memMask[srcAddr] <= {ENTRY_W{1'b1}};
        memAct[srcAddr] <= '0;
        memCnt[srcAddr] <= '0;
      end
      if (wrEn || clrSrcEn) begin
        if (!dis_reg[0] || clrSrcEn) begin
          memVal[wrAddr] <= clrSrcEn ? memVal[srcAddr] : cacheVal[ENTRY_W-1:0];
          memMask[wrAddr] <= clrSrcEn ? memMask[srcAddr] : cacheMask[ENTRY_W-1:0];
        end
        if (!dis_reg[1] || clrSrcEn) begin
          memAct[wrAddr] <= clrSrcEn ? memAct[srcAddr] : cacheAct[ACTION_W-1:0];
        end
        if (!dis_reg[2] || clrSrcEn) begin
          memCnt[wrAddr] <= clrSrcEn ? memCnt[srcAddr] : cacheCnt;
        end
      end
    end
  end

  // cache: clear first, then software words, then loads from memory.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cacheVal <= '1;
      cacheMask <= '1;
      cacheAct <= '0;
      cacheCnt <= '0;
    end else if (ce) begin
      if (clearCache) begin
        cacheVal <= '1;
        cacheMask <= '1;
        cacheAct <= '0;
        cacheCnt <= '0;
      end else if (cacheWrEn) begin
        case (cacheField)
          `CMRS_FLD_VALUE: cacheVal[cacheReplica*W +: W] <= cacheWrData;
          `CMRS_FLD_MASK: cacheMask[cacheReplica*W +: W] <= cacheWrData;
          `CMRS_FLD_ACTION: cacheAct[cacheReplica*W +: W] <= cacheWrData;
          `CMRS_FLD_STICKY: cacheCnt <= cacheWrData[0] ? (cacheCnt | CNT_W'(1)) : '0;
          `CMRS_FLD_WORDWIDE: cacheCnt <= cacheWrData[CNT_W-1:0];
          default: cacheCnt <= cacheCnt;
        endcase
      end else if (loadEn) begin
        if (!dis_reg[0] || clrSrcEn) begin
          cacheVal <= PADW'(memVal[srcAddr]);
          cacheMask <= PADW'(memMask[srcAddr]);
        end
        if (!dis_reg[1] || clrSrcEn) begin
          cacheAct <= PADW'(memAct[srcAddr]);
        end
        if (!dis_reg[2] || clrSrcEn) begin
          cacheCnt <= memCnt[srcAddr];
        end
      end
    end
  end

  always_comb begin
    case (cacheField)
      `CMRS_FLD_VALUE: cacheRdData_next = cacheVal[cacheReplica*W +: W];
      `CMRS_FLD_MASK: cacheRdData_next = cacheMask[cacheReplica*W +: W];
      `CMRS_FLD_ACTION: cacheRdData_next = cacheAct[cacheReplica*W +: W];
      `CMRS_FLD_STICKY: cacheRdData_next = W'(|cacheCnt);
      `CMRS_FLD_WORDWIDE: cacheRdData_next = W'(cacheCnt);
      default: cacheRdData_next = '0;
    endcase
    poolOwnerRd_next = owner_reg[poolIdx_reg];
  end

  // pool allocation; an owned block cannot be handed to another owner.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      poolIdx_reg <= '0;
      poolOwnerRd_reg <= `CMRS_OWNER_FREE;
      cacheRdData_reg <= '0;
      for (int b = 0; b < NBLK; b++) begin
        owner_reg[b] <= `CMRS_OWNER_FREE;
      end
    end else if (ce) begin
      poolOwnerRd_reg <= poolOwnerRd_next;
      cacheRdData_reg <= cacheRdData_next;
      if (poolIdxWrEn) begin
        poolIdx_reg <= pool_block_index;
      end
      if (poolMapWrEn && owner_reg[poolIdx_reg] == `CMRS_OWNER_FREE) begin
        owner_reg[poolIdx_reg] <= pool_block_owner_map;
      end
    end
  end

  assign frameReady = frameReady_reg;
  assign resultValid = resultValid_reg;
  assign resultHit = resultHit_reg;
  assign resultKeyNum = resultKeyNum_reg;
  assign resultAddr = resultAddr_reg;
  assign resultAction = resultAction_reg;
  assign opBusy = opBusy_reg;
  assign cacheRdData = cacheRdData_reg;
  assign poolOwnerRd = poolOwnerRd_reg;

  a_write_done: assert property (ce && opStart && opCmd == `CMRS_CMD_WRITE ##1 ce |=> !opBusy_reg)
    else $error("write operation did not finish in one cycle");
  a_top_priority: assert property (anyHit |-> (hitVec >> winIdx) == DEPTH'(1))
    else $error("a higher matching address was not chosen");
  a_default_rule: assert property (ce && lookupGo && !anyHit |=> resultValid_reg && !resultHit_reg &&
                                   resultAddr_reg == AW'(DEPTH) + AW'($past(curDef)))
    else $error("default rule not reported on a miss");
  a_hit_result: assert property (ce && lookupGo && anyHit |=> resultHit_reg && resultAddr_reg == $past(winIdx))
    else $error("hit address not reported");
  a_disabled_entry: assert property (|(memVal[0] & memMask[0]) |-> !hitVec[0])
    else $error("disabled entry matched");
  a_cnt_saturate: assert property (ce && lookupGo && anyHit && state_reg == cmrs_pkg::OP_IDLE &&
                                   memCnt[winIdx] == {CNT_W{1'b1}} |=> memCnt[$past(winIdx)] == {CNT_W{1'b1}})
    else $error("hit counter wrapped");
  a_cache_clear: assert property (ce && clearCache |=> cacheCnt == '0 && cacheAct == '0 && &cacheMask)
    else $error("cache clear incomplete");
  a_second_key: assert property (ce && frameValid && frameReady_reg && lookupEnable && !keyPend_reg &&
                                 portSecondKey[framePort] |=> keyPend_reg && !frameReady_reg)
    else $error("second key not issued");
endmodule

// ---- testbench/cmrs_frame_source.sv ----
// Frame key generator model that presents frames together with their default choice.
`timescale 1ns/1ps
module cmrs_frame_source (
  // Clock and flow control.
  input wire logic clk,
  input wire logic frameReady,
  // Frame towards the rule store.
  output logic frameValid,
  output logic [3:0] frameType,
  output logic [3:0] framePort,
  output logic [3:0] classResult,
  output logic [43:0] frameFields,
  output logic defaultSel
);
  initial begin
    frameValid = 1'b0;
    {frameType, framePort, classResult, frameFields, defaultSel} = '0;
  end
  // Released data is inverted so a stale value never looks valid.
  task automatic send(input logic [3:0] t, input logic [3:0] p, input logic [3:0] c, input logic [43:0] f,
                      input logic d);
    @(posedge clk);
    frameValid <= 1'b1;
    {frameType, framePort, classResult, frameFields} <= {t, p, c, f};
    defaultSel <= d;
    @(posedge clk);
    while (frameReady !== 1'b1) @(posedge clk);
    frameValid <= 1'b0;
    {frameType, framePort, classResult, frameFields, defaultSel} <= ~{t, p, c, f, d};
  endtask
endmodule

// ---- testbench/content_match_rule_store_bench.sv ----
// Self-checking bench with a queue-based reference model of the rule store.
`timescale 1ns/1ps
module content_match_rule_store_bench;
  localparam logic [415:0] DIS = {236'h0, {52{1'b1}}, 76'h0, {52{1'b1}}};
  logic clk = 1'b0;
  logic rstB, lookupEnable, frameValid, frameReady, resultValid, resultHit, resultKeyNum, trig, clearCache, opBusy;
  logic cacheWrEn, poolIdxWrEn, poolMapWrEn, defaultSel, ce;
  logic [2:0] updDis;
  logic [3:0] frameType, framePort, classResult;
  logic [43:0] frameFields;
  logic [15:0] portSecondKey;
  logic [5:0] resultAddr, opAddr, moveNumPos, moveSize;
  logic [109:0] resultAction;
  logic [2:0] opCmd, cacheField, poolMap, poolOwnerRd;
  logic [1:0] cacheReplica, poolIdx;
  logic [31:0] cacheWrData, cacheRdData, d;
  logic [415:0] mem[34], cache;
  logic [117:0] expQ[$];
  int owner[4] = '{default: 0};
  int numErrors = 0;
  int nTests = 0;
  integer seed = 32'h9ed35874;
  always #50 clk = ~clk;
  content_match_rule_store i_content_match_rule_store (
    .clk(clk), .rst_b(rstB), .ce(ce), .lookupEnable(lookupEnable), .frameValid(frameValid),
    .frameType(frameType), .framePort(framePort), .classResult(classResult), .frameFields(frameFields),
    .defaultSel(defaultSel), .portSecondKey(portSecondKey), .frameReady(frameReady),
    .resultValid(resultValid), .resultHit(resultHit), .resultKeyNum(resultKeyNum), .resultAddr(resultAddr),
    .resultAction(resultAction), .operation_trigger(trig), .opCmd(opCmd), .opAddr(opAddr),
    .clearCache(clearCache), .entryUpdateDis(updDis[0]), .actionUpdateDis(updDis[1]), .cntUpdateDis(updDis[2]),
    .moveNumPos(moveNumPos), .moveSize(moveSize), .opBusy(opBusy), .cacheWrEn(cacheWrEn),
    .cacheField(cacheField), .cacheReplica(cacheReplica), .cacheWrData(cacheWrData),
    .cacheRdData(cacheRdData), .poolIdxWrEn(poolIdxWrEn), .pool_block_index(poolIdx),
    .poolMapWrEn(poolMapWrEn), .pool_block_owner_map(poolMap), .poolOwnerRd(poolOwnerRd));
  cmrs_frame_source i_cmrs_frame_source (
    .clk(clk), .frameReady(frameReady), .frameValid(frameValid), .frameType(frameType),
    .framePort(framePort), .classResult(classResult), .frameFields(frameFields), .defaultSel(defaultSel));
  task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
    nTests++;
    if (seen !== exp) begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Model of an operation that skips the entry, action or counter part whose disable bit is set.
  function automatic logic [415:0] upd(input logic [415:0] o, input logic [415:0] n);
    upd = n;
    if (updDis[0]) upd[255:0] = o[255:0];
    if (updDis[1]) upd[383:256] = o[383:256];
    if (updDis[2]) upd[415:384] = o[415:384];
  endfunction
  task automatic giveVerdict();
    if (numErrors == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] f, input logic [1:0] r, input logic [31:0] x);
    @(posedge clk);
    {cacheWrEn, cacheField, cacheReplica, cacheWrData} <= {1'b1, f, r, x};
    @(posedge clk);
    cacheWrEn <= 1'b0;
    cache[(f == 3'h3) ? 384 : 128 * f + 32 * r +: 32] = (f == 3'h3) ? {31'h0, x[0]} : x;
  endtask
  task automatic rd(input logic [2:0] f, input logic [1:0] r);
    @(posedge clk);
    {cacheField, cacheReplica} <= {f, r};
    repeat (2) @(posedge clk);
    d = cacheRdData;
  endtask
  task automatic op(input logic [2:0] c, input int a, input int n, input int s, input logic clr);
    int src;
    int cnt;
    @(posedge clk);
    {trig, opCmd, opAddr, moveNumPos, moveSize, clearCache} <= {1'b1, c, 6'(a), 6'(n), 6'(s), clr};
    @(posedge clk);
    {trig, clearCache} <= 2'b00;
    @(negedge clk);
    check("opBusy", opBusy, 1'b1);
    cnt = 0;
    while (opBusy === 1'b1 && cnt < 100) begin
      cnt++;
      @(negedge clk);
    end
    check("opDone", opBusy, 1'b0);
    check("opCycles", cnt, (c == 3'h4) ? n + 1 : (c[2:1] == 2'h1) ? s + 1 : 1);
    if (clr) cache = DIS;
    case (c)
      3'h0: mem[a] = upd(mem[a], cache);
      3'h1: cache = upd(cache, mem[a]);
      3'h4: for (int i = a; i <= a + n; i++) mem[i] = upd(mem[i], cache);
      default: for (int i = 0; i <= s; i++) begin
        src = (c == 3'h2) ? a + i : a + s - i;
        mem[(c == 3'h2) ? src - n : src + n] = mem[src];
        cache = mem[src];
        mem[src] = DIS;
      end
    endcase
  endtask
  task automatic prog(input int a, input logic [51:0] v, input logic [51:0] m);
    wr(3'h0, 2'h0, v[31:0]);
    wr(3'h0, 2'h1, {12'h0, v[51:32]});
    wr(3'h1, 2'h0, m[31:0]);
    wr(3'h1, 2'h1, {12'h0, m[51:32]});
    wr(3'h2, 2'h0, $random(seed));
    op(3'h0, a, 0, 0, 1'b0);
  endtask
  task automatic pool(input logic [1:0] b, input logic [2:0] o);
    @(posedge clk);
    {poolIdxWrEn, poolIdx} <= {1'b1, b};
    @(posedge clk);
    {poolIdxWrEn, poolMapWrEn, poolMap} <= {2'b01, o};
    @(posedge clk);
    poolMapWrEn <= 1'b0;
    if (owner[b] == 0) owner[b] = o;
    repeat (2) @(posedge clk);
    check("poolOwnerRd", poolOwnerRd, 3'(owner[b]));
  endtask
  task automatic expectKey(input logic [51:0] key, input logic kn, input logic dsel);
    int h;
    h = 32 + dsel;
    for (int a = 0; a < 32; a++)
      if (owner[a / 8] == 1 && (mem[a][51:0] & mem[a][179:128]) == 52'h0
          && ((key ^ mem[a][51:0]) & ~mem[a][179:128]) == 52'h0) h = a;
    if (h < 32) mem[h][384] = 1'b1;
    expQ.push_back({h < 32, kn, 6'(h), mem[h][365:256]});
  endtask
  task automatic frame(input logic [3:0] t, input logic [3:0] p, input logic [3:0] c, input logic [43:0] f,
                       input logic dsel);
    if (lookupEnable) begin
      expectKey({t, p, f}, 1'b0, dsel);
      if (portSecondKey[p]) expectKey({t, c, f}, 1'b1, dsel);
    end
    i_cmrs_frame_source.send(t, p, c, f, dsel);
  endtask
  task automatic randFrames(input int n);
    logic [31:0] r;
    for (int i = 0; i < n; i++) begin
      r = $random(seed);
      frame(4'h4 + r[1:0], {2'h0, r[3:2]}, r[7:4], {r[31:8], r[19:0]}, r[8]);
    end
  endtask
  always @(posedge clk) begin
    if (resultValid === 1'b1) begin
      if (expQ.size() == 0) check("strayResult", 1'b1, 1'b0);
      else check("result", {resultHit, resultKeyNum, resultAddr, resultAction}, expQ.pop_front());
    end
  end
  initial begin
    {rstB, lookupEnable, trig, clearCache, cacheWrEn, poolIdxWrEn, poolMapWrEn} = '0;
    {ce, updDis} = 4'h8;
    {opCmd, opAddr, moveNumPos, moveSize, cacheField, cacheReplica, cacheWrData, poolIdx, poolMap} = '0;
    portSecondKey = 16'h0002;
    repeat (20) @(posedge clk);
    rstB <= 1'b1;
    pool(2'h0, 3'h1);
    pool(2'h0, 3'h2);
    pool(2'h1, 3'h2);
    op(3'h4, 0, 33, 0, 1'b1);
    prog(2, {4'h6, 40'h0, 8'hA5}, {4'h0, {40{1'b1}}, 8'h00});
    prog(3, {4'h5, 48'h0}, {4'h0, {48{1'b1}}});
    prog(5, {4'h5, 4'h1, 44'h0}, {8'h0, {44{1'b1}}});
    prog(7, 52'h1, {52{1'b1}});
    prog(9, 52'h0, {52{1'b1}});
    prog(32, 52'h0, 52'h0);
    prog(33, 52'h0, 52'h0);
    @(posedge clk);
    lookupEnable <= 1'b1;
    @(posedge clk);
    frame(4'h5, 4'h1, 4'h3, 44'h0, 1'b0);
    frame(4'h6, 4'h0, 4'h0, 44'h12345A5, 1'b1);
    frame(4'h6, 4'h2, 4'h0, 44'h12345A4, 1'b1);
    randFrames(40);
    wr(3'h3, 2'h0, 32'h1);
    op(3'h0, 7, 0, 0, 1'b0);
    op(3'h3, 2, 4, 1, 1'b0);
    randFrames(10);
    op(3'h2, 6, 4, 1, 1'b0);
    randFrames(10);
    lookupEnable <= 1'b0;
    @(posedge clk);
    frame(4'h5, 4'h1, 4'h3, 44'h0, 1'b0);
    repeat (4) @(posedge clk);
    wr(3'h3, 2'h0, 32'h0);
    updDis <= 3'b011;
    op(3'h4, 4, 1, 0, 1'b0);
    @(posedge clk);
    updDis <= 3'b000;
    foreach (owner[k]) begin
      for (int a = 2; a < 8; a++) begin
        if (k == 0) begin
          op(3'h1, a, 0, 0, 1'b0);
          rd(3'h3, 2'h0);
          check("sticky", d[0], mem[a][384]);
          rd(3'h0, 2'h1);
          check("valueHigh", d[19:0], mem[a][51:32]);
          rd(3'h4, 2'h0);
          check("wordwide", d[0], mem[a][384]);
        end
      end
    end
    @(posedge clk);
    {ce, cacheWrEn, cacheField, cacheReplica, cacheWrData} <= {2'b01, 3'h2, 2'h0, 32'h5A5A5A5A};
    @(posedge clk);
    {ce, cacheWrEn} <= 2'b10;
    rd(3'h2, 2'h0);
    check("frozenAction", d, cache[287:256]);
    wr(3'h2, 2'h0, 32'h5A5A5A5A);
    wr(3'h0, 2'h0, 32'h0);
    @(posedge clk);
    clearCache <= 1'b1;
    @(posedge clk);
    clearCache <= 1'b0;
    rd(3'h0, 2'h0);
    check("clearedValue", d, 32'hFFFFFFFF);
    rd(3'h2, 2'h0);
    check("clearedAction", d, 32'h0);
    repeat (5) @(posedge clk);
    check("pending", expQ.size(), 0);
    giveVerdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    giveVerdict();
  end
endmodule
